// [core/rsc_consts.svh]
// constants of the reset status and system options block
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// ----------------------------------------------------------------------
// register select codes on the access port
// ----------------------------------------------------------------------
`define RSC_SEL_CAUSE        2'h0
`define RSC_SEL_DEBUG_RESET  2'h1
`define RSC_SEL_OPTIONS      2'h2

// ----------------------------------------------------------------------
// reset cause register bit positions
// ----------------------------------------------------------------------
`define RSC_BIT_POWER_ON     7
`define RSC_BIT_PIN          6
`define RSC_BIT_WATCHDOG     5
`define RSC_BIT_BAD_OPCODE   4
`define RSC_BIT_BAD_ADDRESS  3
`define RSC_BIT_CLOCK_LOSS   2
`define RSC_BIT_LOW_VOLTAGE  1

// ----------------------------------------------------------------------
// system options one bit positions and debug register trigger bit
// ----------------------------------------------------------------------
`define RSC_OPT_TIMEOUT_HI   7
`define RSC_OPT_TIMEOUT_LO   6
`define RSC_OPT_STOP         5
`define RSC_OPT_BOOT_PIN     2
`define RSC_OPT_DEBUG_PIN    1
`define RSC_OPT_RESET_PIN    0
`define RSC_BIT_DEBUG_TRIG   0

// ----------------------------------------------------------------------
// reset values and watchdog sequence keys
// ----------------------------------------------------------------------
`define RSC_CAUSE_POR_VALUE  8'h82
`define RSC_CAUSE_LV_MASK    8'h82
`define RSC_TIMEOUT_RESET    2'h3
`define RSC_TIMEOUT_OFF      2'h0
`define RSC_KEY_FIRST        8'h55
`define RSC_KEY_SECOND       8'hAA
`define RSC_READ_ZERO        8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RSC_RESET_HOLD_CYCLES 4

`endif

// [core/rsc_pkg.sv]
// types of the reset status and system options block
package rsc_pkg;

    typedef enum logic [1:0] {
        RSC_RUN  = 2'b01,
        RSC_HOLD = 2'b10
    } rsc_state_t;

endpackage

// [core/rsc_top.sv]
// reset cause flags, debug forced reset and write-once system options
`timescale 1ns/1ps
`include "rsc_consts.svh"

// What this block does
// - seven read-only flags record last reset cause
// - debug forced reset leaves all flags clear, unless a low-voltage reset in the same cycle sets its flags
// - bad watchdog-address write resets when watchdog enabled
// - key pair clears watchdog, flags unchanged
// - power-on sets power-on and low-voltage flags
// - low-voltage reset: set low-voltage, keep power-on, clear others
// - bit 6: external reset pin caused reset
// - bit 5: watchdog timeout, blocked when disabled
// - bit 4: illegal opcode, disallowed stop or background
// - bit 3: unimplemented address access
// - bit 2: loss of external clock
// - bit 1: low-voltage trip or power-on
// - debug register: debug writes only, reads zero
// - options readable, only first write honoured
// - options bits 4 and 3 read zero
// - timeout select bits 7:6 reset to ones
// - stop bit resets zero; stop then illegal
// - boot pin state latched at power-on, cleared by other resets
// - debug pin enable resets one; reset pin kept
// - reset pin enable makes pin reset input

module rsc_top #(
    parameter int HOLD_CYCLES = `RSC_RESET_HOLD_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] reg_sel,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic       wr_from_debug,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    input  wire logic       ext_reset_pin_n,
    input  wire logic       wdog_expired,
    input  wire logic       bad_opcode,
    input  wire logic       stop_exec,
    input  wire logic       enter_background_instruction_exec,
    input  wire logic       background_mode_allow,
    input  wire logic       bad_address,
    input  wire logic       clock_loss,
    input  wire logic       lv_trip,
    input  wire logic       lv_detect_enable,
    input  wire logic       boot_select_pin,
    input  wire logic       mode_pin,
    output logic            sys_reset,
    output logic            wdog_clear,
    output logic      [1:0] watchdog_timeout_select,
    output logic            stop_allow_bit,
    output logic            debug_pin_enable,
    output logic            reset_pin_enable,
    output logic            boot_pin_latched_state
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    rsc_pkg::rsc_state_t state;
    logic [7:0]          cause_flags;
    logic [7:0]          hold_cnt;
    logic                options_written;
    logic                boot_capture_pending;

    logic run;
    logic sel_cause;
    logic sel_options;
    logic sel_debug;
    logic wd_en;
    logic seq_done;
    logic seq_bad;
    logic pin_req;
    logic wd_req;
    logic op_req;
    logic ad_req;
    logic ck_req;
    logic lv_req;
    logic dbg_req;
    logic any_req;
    logic [7:0] next_flags;
    logic [7:0] next_rd;

    function automatic logic [7:0] options_view(
        input logic [1:0] tsel,
        input logic       stp,
        input logic       boot,
        input logic       dbgp,
        input logic       rstp
    );
        logic [7:0] v;
        v = 8'h00;
        v[`RSC_OPT_TIMEOUT_HI:`RSC_OPT_TIMEOUT_LO] = tsel;
        v[`RSC_OPT_STOP]      = stp;
        v[`RSC_OPT_BOOT_PIN]  = boot;
        v[`RSC_OPT_DEBUG_PIN] = dbgp;
        v[`RSC_OPT_RESET_PIN] = rstp;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // decode and reset requests
    // ------------------------------------------------------------------
    always_comb begin
        run         = (state == rsc_pkg::RSC_RUN);
        sel_cause   = (reg_sel == `RSC_SEL_CAUSE);
        sel_options = (reg_sel == `RSC_SEL_OPTIONS);
        sel_debug   = (reg_sel == `RSC_SEL_DEBUG_RESET);
        wd_en       = (watchdog_timeout_select != `RSC_TIMEOUT_OFF);
        pin_req     = reset_pin_enable && !ext_reset_pin_n;
        wd_req      = wd_en && (wdog_expired || seq_bad);
        op_req      = bad_opcode
                   || (stop_exec && !stop_allow_bit)
                   || (enter_background_instruction_exec && !background_mode_allow);
        ad_req      = bad_address;
        ck_req      = clock_loss;
        lv_req      = lv_trip && lv_detect_enable;
        dbg_req     = reg_wr && wr_from_debug && sel_debug
                   && wr_data[`RSC_BIT_DEBUG_TRIG];
        any_req     = run && (pin_req || wd_req || op_req || ad_req
                   || ck_req || lv_req || dbg_req);
    end

    rsc_wdog_seq u_seq (
        .clk        (clk),
        .rst        (rst),
        .sync_clear (any_req),
        .wr_stb     (run && reg_wr && sel_cause),
        .wr_data    (wr_data),
        .key_done   (seq_done),
        .bad_write  (seq_bad)
    );

    // ------------------------------------------------------------------
    // cause flags
    // ------------------------------------------------------------------
    always_comb begin
        next_flags = 8'h00;
        if (lv_req) begin
            next_flags = `RSC_CAUSE_LV_MASK
                       & {cause_flags[`RSC_BIT_POWER_ON], 7'h7f};
        end else if (dbg_req) begin
            next_flags = 8'h00;
        end else begin
            next_flags[`RSC_BIT_PIN]         = pin_req;
            next_flags[`RSC_BIT_WATCHDOG]    = wd_req;
            next_flags[`RSC_BIT_BAD_OPCODE]  = op_req;
            next_flags[`RSC_BIT_BAD_ADDRESS] = ad_req;
            next_flags[`RSC_BIT_CLOCK_LOSS]  = ck_req;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_flags <= `RSC_CAUSE_POR_VALUE;
        end else if (any_req) begin
            cause_flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= rsc_pkg::RSC_RUN;
            hold_cnt <= 8'h00;
        end else begin
            case (state)
                rsc_pkg::RSC_RUN: begin
                    if (any_req) begin
                        state    <= rsc_pkg::RSC_HOLD;
                        hold_cnt <= 8'(HOLD_CYCLES - 1);
                    end
                end
                rsc_pkg::RSC_HOLD: begin
                    if (hold_cnt == 8'h00) begin
                        state <= rsc_pkg::RSC_RUN;
                    end else begin
                        hold_cnt <= hold_cnt - 8'h01;
                    end
                end
                default: begin
                    state <= rsc_pkg::RSC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_reset <= 1'b0;
        end else if (any_req) begin
            sys_reset <= 1'b1;
        end else if (state == rsc_pkg::RSC_HOLD && hold_cnt == 8'h00) begin
            sys_reset <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdog_clear <= 1'b0;
        end else begin
            wdog_clear <= seq_done && !any_req;
        end
    end

    // ------------------------------------------------------------------
    // system options one
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_timeout_select <= `RSC_TIMEOUT_RESET;
            stop_allow_bit          <= 1'b0;
            debug_pin_enable        <= 1'b1;
            reset_pin_enable        <= 1'b0;
            options_written         <= 1'b0;
        end else if (any_req) begin
            watchdog_timeout_select <= `RSC_TIMEOUT_RESET;
            stop_allow_bit          <= 1'b0;
            debug_pin_enable        <= 1'b1;
            options_written         <= 1'b0;
        end else if (run && reg_wr && sel_options && !options_written) begin
            watchdog_timeout_select <=
                wr_data[`RSC_OPT_TIMEOUT_HI:`RSC_OPT_TIMEOUT_LO];
            stop_allow_bit          <= wr_data[`RSC_OPT_STOP];
            debug_pin_enable        <= wr_data[`RSC_OPT_DEBUG_PIN];
            reset_pin_enable        <= wr_data[`RSC_OPT_RESET_PIN];
            options_written         <= 1'b1;
        end
    end

    // boot pin sampled on the first edge after power-on release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_capture_pending   <= 1'b1;
            boot_pin_latched_state <= 1'b0;
        end else if (boot_capture_pending) begin
            boot_capture_pending   <= 1'b0;
            boot_pin_latched_state <= !boot_select_pin && mode_pin;
        end else if (any_req) begin
            boot_pin_latched_state <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        next_rd = `RSC_READ_ZERO;
        if (sel_cause) begin
            next_rd = {cause_flags[7:1], 1'b0};
        end else if (sel_options) begin
            next_rd = options_view(watchdog_timeout_select,
                                   stop_allow_bit,
                                   boot_pin_latched_state,
                                   debug_pin_enable,
                                   reset_pin_enable);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= `RSC_READ_ZERO;
        end else if (reg_rd) begin
            rd_data <= next_rd;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_por_flags: assert property (
        boot_capture_pending |-> cause_flags == 8'h82)
        else $error("power-on flags not set");

    chk_debug_clears: assert property (
        run && dbg_req && !lv_req |=> cause_flags == 8'h00 && sys_reset)
        else $error("debug reset left a flag set");

    chk_bad_key_reset: assert property (
        run && reg_wr && sel_cause && wd_en && wr_data != 8'h55
        && wr_data != 8'hAA && !lv_req && !dbg_req
        |=> sys_reset && cause_flags[5])
        else $error("bad watchdog write did not reset");

    chk_key_pair: assert property (
        (run && reg_wr && sel_cause && wr_data == 8'h55 && !any_req)
        ##1 (reg_wr && sel_cause && wr_data == 8'hAA && !any_req)
        |=> wdog_clear && $stable(cause_flags))
        else $error("key pair did not clear watchdog");

    chk_low_voltage: assert property (
        run && lv_req |=> cause_flags[6:2] == 5'h00 && cause_flags[1]
        && cause_flags[7] == $past(cause_flags[7]))
        else $error("low-voltage flags wrong");

    chk_pin_flag: assert property (
        run && pin_req && !lv_req && !dbg_req |=> cause_flags[6])
        else $error("pin flag not set");

    chk_wdog_block: assert property (
        run && wdog_expired && !wd_en && !reg_wr && !pin_req && !op_req
        && !ad_req && !ck_req && !lv_req |=> !sys_reset)
        else $error("disabled watchdog caused reset");

    chk_stop_illegal: assert property (
        run && stop_exec && !stop_allow_bit && !lv_req && !dbg_req
        |=> cause_flags[4] && !stop_allow_bit)
        else $error("disallowed stop missed");

    chk_debug_read: assert property (
        reg_rd && sel_debug |=> rd_data == 8'h00)
        else $error("debug register read not zero");

    chk_write_once: assert property (
        options_written && !any_req |=>
        $stable(watchdog_timeout_select) && $stable(stop_allow_bit)
        && $stable(reset_pin_enable))
        else $error("second options write honoured");

    chk_unused_bits: assert property (
        reg_rd |=> rd_data[0] == 1'b0 || $past(reg_sel) != 2'h0)
        else $error("cause bit 0 not zero");

    chk_options_gap: assert property (
        reg_rd && sel_options |=> rd_data[4:3] == 2'h0)
        else $error("options bits 4 and 3 not zero");

    cov_debug_reset: cover property (run && dbg_req);
    cov_key_clear:   cover property (wdog_clear);
    cov_options_set: cover property ($rose(options_written));
    cov_lv_reset:    cover property (run && lv_req);

endmodule

// [core/rsc_wdog_seq.sv]
// watchdog clear key sequence tracker on the reset cause address
`timescale 1ns/1ps
`include "rsc_consts.svh"

module rsc_wdog_seq (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sync_clear,
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    output logic            key_done,
    output logic            bad_write
);

    logic armed;

    always_comb begin
        key_done  = wr_stb && armed && (wr_data == `RSC_KEY_SECOND);
        bad_write = wr_stb && (wr_data != `RSC_KEY_FIRST)
                           && (wr_data != `RSC_KEY_SECOND);
    end

    // first key arms, any other write disarms
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (sync_clear) begin
            armed <= 1'b0;
        end else if (wr_stb) begin
            armed <= (wr_data == `RSC_KEY_FIRST);
        end
    end

endmodule

// [testbench/rsc_host.sv]
// register port host model: cpu software and serial debug engine
`timescale 1ns/1ps

module rsc_host (
    input  wire logic       clk,
    output logic      [1:0] reg_sel,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            wr_from_debug,
    output logic      [7:0] wr_data
);
    initial begin
        reg_sel = 2'h3;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wr_from_debug = 1'b0;
        wr_data = 8'h00;
    end

    // ------------------------------------------------------------------
    // one access, held over one rising edge
    // ------------------------------------------------------------------
    // kind: 0 read, 1 program write, 2 debug engine write
    task automatic access(input int kind, input logic [1:0] sel,
                          input logic [7:0] data);
        reg_sel = sel;
        reg_rd = (kind == 0);
        reg_wr = (kind != 0);
        wr_from_debug = (kind == 2);
        wr_data = data;
        @(posedge clk);
        #1;
    endtask

    // released data shows no stale value
    task automatic idle();
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        wr_from_debug = 1'b0;
        reg_sel = 2'h3;
        wr_data = ~wr_data;
    endtask
endmodule

// [testbench/test_reset_status_and_system_options.sv]
// self-checking bench of the reset status and system options block
`timescale 1ns/1ps

module test_reset_status_and_system_options;
    localparam int HOLD = 3;
    // cause flags per source: pin, wdog, opcode, stop, enter_background_instruction, addr, clk, lv
    localparam logic [7:0] CAUSE [8] = '{8'h40, 8'h20, 8'h10, 8'h10,
                                         8'h10, 8'h08, 8'h04, 8'h02};
    logic       clk;
    logic       rst;
    logic [1:0] reg_sel;
    logic       reg_wr;
    logic       reg_rd;
    logic       wr_from_debug;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] src;
    logic       boot_select_pin;
    logic       mode_pin;
    logic       background_mode_allow;
    logic       lv_detect_enable;
    logic       sys_reset;
    logic       wdog_clear;
    logic [1:0] watchdog_timeout_select;
    logic       stop_allow_bit;
    logic       debug_pin_enable;
    logic       reset_pin_enable;
    logic       boot_pin_latched_state;
    logic [7:0] got;
    int         errors;
    int         n_checks;
    int         rs_n;
    int         wc_n;

    rsc_host host (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .wr_from_debug(wr_from_debug), .wr_data(wr_data));

    rsc_top #(.HOLD_CYCLES(HOLD)) dut (.clk(clk), .rst(rst),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .wr_from_debug(wr_from_debug), .wr_data(wr_data),
        .rd_data(rd_data), .ext_reset_pin_n(~src[0]),
        .wdog_expired(src[1]), .bad_opcode(src[2]), .stop_exec(src[3]),
        .enter_background_instruction_exec(src[4]), .background_mode_allow(background_mode_allow),
        .bad_address(src[5]), .clock_loss(src[6]), .lv_trip(src[7]),
        .lv_detect_enable(lv_detect_enable),
        .boot_select_pin(boot_select_pin), .mode_pin(mode_pin),
        .sys_reset(sys_reset), .wdog_clear(wdog_clear),
        .watchdog_timeout_select(watchdog_timeout_select),
        .stop_allow_bit(stop_allow_bit),
        .debug_pin_enable(debug_pin_enable),
        .reset_pin_enable(reset_pin_enable),
        .boot_pin_latched_state(boot_pin_latched_state));

    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // read strobe left up: repeated reads have no side effect
    task automatic cmp_reg(input string what, input logic [1:0] sel,
                           input logic [7:0] exp);
        host.access(0, sel, 8'h00);
        got = rd_data;
        chk(what, exp, got);
    endtask

    task automatic wr(input int kind, input logic [1:0] sel,
                      input logic [7:0] d);
        host.access(kind, sel, d);
        host.idle();
    endtask

    // counts reset and clear cycles over a fixed window
    task automatic watch();
        rs_n = 0;
        wc_n = 0;
        repeat (12) begin
            rs_n += (sys_reset === 1'b1);
            wc_n += (wdog_clear === 1'b1);
            @(posedge clk);
            #1;
        end
    endtask

    task automatic pulse(input int i);
        src[i] = 1'b1;
        @(posedge clk);
        #1;
        src[i] = 1'b0;
    endtask

    task automatic give_verdict();
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_power_on();
        cmp_reg("cause", 2'h0, 8'h82);
        cmp_reg("options", 2'h2, 8'hC6);
        pulse(0);
        watch();
        chk("pin while port", 8'h00, rs_n[7:0]);
        pulse(7);
        watch();
        chk("lv resets", 8'(HOLD), rs_n[7:0]);
        cmp_reg("cause", 2'h0, 8'h82);
    endtask

    task automatic t_options();
        host.access(1, 2'h2, 8'hFF);
        cmp_reg("options", 2'h2, 8'hE3);
        chk("option outs", 8'h1F, {2'h0, boot_pin_latched_state,
            watchdog_timeout_select, stop_allow_bit, debug_pin_enable,
            reset_pin_enable});
        host.access(1, 2'h2, 8'h00);
        cmp_reg("options", 2'h2, 8'hE3);
    endtask

    task automatic t_debug_reg();
        cmp_reg("debug reg", 2'h1, 8'h00);
        wr(1, 2'h1, 8'h01);
        watch();
        chk("program force", 8'h00, rs_n[7:0]);
        wr(2, 2'h1, 8'h01);
        watch();
        chk("debug force", 8'(HOLD), rs_n[7:0]);
        cmp_reg("cause", 2'h0, 8'h00);
        cmp_reg("options", 2'h2, 8'hC3);
    endtask

    task automatic t_sources();
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            watch();
            chk("source resets", 8'(HOLD), rs_n[7:0]);
            cmp_reg("cause", 2'h0, CAUSE[i]);
        end
    endtask

    task automatic t_key();
        host.access(1, 2'h0, 8'h55);
        host.access(1, 2'h0, 8'hAA);
        host.idle();
        watch();
        chk("key clears", 8'h01, wc_n[7:0]);
        chk("key resets", 8'h00, rs_n[7:0]);
        cmp_reg("cause", 2'h0, 8'h04);
        wr(1, 2'h0, 8'h12);
        watch();
        chk("bad key resets", 8'(HOLD), rs_n[7:0]);
        cmp_reg("cause", 2'h0, 8'h20);
    endtask

    task automatic t_disabled();
        pulse(7);
        watch();
        cmp_reg("cause", 2'h0, 8'h02);
        wr(1, 2'h2, 8'h00);
        background_mode_allow = 1'b1;
        pulse(1);
        @(posedge clk);
        #1;
        pulse(4);
        wr(1, 2'h0, 8'h12);
        watch();
        chk("disabled resets", 8'h00, rs_n[7:0]);
        cmp_reg("cause", 2'h0, 8'h02);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        src = 8'h00;
        boot_select_pin = 1'b0;
        mode_pin = 1'b1;
        background_mode_allow = 1'b0;
        lv_detect_enable = 1'b1;
        errors = 0;
        n_checks = 0;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        t_power_on();
        t_options();
        t_debug_reg();
        t_sources();
        t_key();
        t_disabled();
        give_verdict();
    end

    initial begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule
